// ==== ccr_defs.svh ====
/*
 * Offsets, field positions, reset values and bus codes of the cluster
 * capability register group.
 * Assumes byte addressing on a 32-bit Avalon-MM register bus.
 */
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH

`define CCR_ADDR_W          12
`define CCR_DATA_W          32
`define CCR_BE_W            4
`define CCR_NUM_CORES       16
`define CCR_FIELD_W         2
`define CCR_NUM_PLL         16

`define CCR_OFF_PLL         12'hFB0
`define CCR_OFF_THREAD      12'hFB4

`define CCR_RST_THREAD      32'h0000_0000
`define CCR_RST_PLL         32'h0000_0007
`define CCR_THREAD_TWO_DEF  16'h0000
`define CCR_PLL_ABSENT_DEF  16'h0007
`define CCR_PLL_RSVD_ZERO   16'h0000
`define CCR_RDATA_RST       32'h0000_0000
// upper bit of every thread field; only a reserved code would set one
`define CCR_THREAD_HI_BITS  32'hAAAA_AAAA

`define CCR_RESP_OKAY       2'h0
`define CCR_RESP_SLVERR     2'h2

`endif

// ==== ccr_pkg.sv ====
/*
 * Types of the cluster capability register group.
 * Assumes ccr_defs.svh is on the include path.
 */
`include "ccr_defs.svh"

package ccr_pkg;

    typedef enum logic [`CCR_FIELD_W-1:0] {
        CCR_THREADS_ONE = 2'h0,
        CCR_THREADS_TWO = 2'h1
    } ccr_thread_enc_t;

    typedef struct packed {
        logic                   read;
        logic                   write;
        logic [`CCR_ADDR_W-1:0] address;
        logic [`CCR_DATA_W-1:0] writedata;
        logic [`CCR_BE_W-1:0]   byteenable;
    } ccr_av_req_t;

endpackage

// ==== ccr_thread_field.sv ====
/*
 * One core thread-count field of the thread capability register.
 * Assumes the thread count is a build-time choice, one or two threads.
 */
`timescale 1ns/1ns
`include "ccr_defs.svh"

module ccr_thread_field #(
    parameter bit TWO_THREADS = 1'b0
) (
    output wire logic [`CCR_FIELD_W-1:0] field_o
);

    // only the two legal codes can ever be produced
    assign field_o = TWO_THREADS ? ccr_pkg::CCR_THREADS_TWO : ccr_pkg::CCR_THREADS_ONE; // RQ3

endmodule // ccr_thread_field

// ==== ccr_cap_regs.sv ====
/*
 * Read-only cluster capability registers (thread capability and PLL
 * presence) behind an Avalon-MM slave with waitrequest.
 * Assumes one clock, synchronous active-high reset and a master that
 * holds its request until it samples waitrequest low.
 */
// The Avalon-MM register port is this design's own decision.
// Notes on behaviour
// RQ1: the thread capability register is a 32-bit read-only word at 0xFB4 that reads zero after reset by default.
// RQ2: core n's 2-bit thread count sits at bits 2n+1 down to 2n, core 15 on top and core 0 at the bottom.
// RQ3: each thread field reads 0 for one thread and 1 for two threads and never shows the reserved codes.
// RQ4: bit n of the PLL presence register reads 0 when PLL clock input n exists and 1 when it is absent.
// RQ5: the thread capability register exists in every build and always answers a read.
// RQ6: bits 31 to 16 of the PLL presence register carry nothing and read zero.
// RQ7: the PLL presence register is a 32-bit read-only word at 0xFB0 whose default value is 0x0000_0007.
// RQ8: both registers are fixed by build parameters, writes change nothing and reserved bits read zero.
`timescale 1ns/1ns
`include "ccr_defs.svh"

module ccr_cap_regs #(
    parameter logic [`CCR_NUM_CORES-1:0] THREAD_TWO_MASK = `CCR_THREAD_TWO_DEF,
    parameter logic [`CCR_NUM_PLL-1:0]   PLL_ABSENT_MASK = `CCR_PLL_ABSENT_DEF
) (
    input  wire logic                   clk_sys_i,
    input  wire logic                   rst_i,
    input  wire ccr_pkg::ccr_av_req_t   av_req_i,
    output logic      [`CCR_DATA_W-1:0] readdata_o,
    output logic      [1:0]             response_o,
    output logic                        waitrequest_o
);

    logic [`CCR_DATA_W-1:0] thread_word;
    logic [`CCR_DATA_W-1:0] pll_word;
    logic                   ack;
    logic                   req;
    logic                   hit_thread;
    logic                   hit_pll;
    logic [`CCR_DATA_W-1:0] next_readdata;
    logic [1:0]             next_response;

    // reference layout built apart from the field instances, so a field
    // wired to the wrong slice cannot agree with itself
    function automatic logic [`CCR_DATA_W-1:0] thread_layout(input logic [`CCR_NUM_CORES-1:0] mask);
        logic [`CCR_DATA_W-1:0] w;
        w = 32'h0000_0000;
        for (int n = 0; n < `CCR_NUM_CORES; n++) begin
            w[n*`CCR_FIELD_W +: `CCR_FIELD_W] = {1'b0, mask[n]}; // RQ2 RQ3
        end
        return w;
    endfunction

    // fields are packed from build parameters, nothing here is writable
    genvar gi;
    generate
        for (gi = 0; gi < `CCR_NUM_CORES; gi++) begin : g_core
            ccr_thread_field #(
                .TWO_THREADS (THREAD_TWO_MASK[gi])
            ) u_field (
                .field_o (thread_word[gi*`CCR_FIELD_W +: `CCR_FIELD_W]) // RQ2
            );
        end
    endgenerate

    assign pll_word = {`CCR_PLL_RSVD_ZERO, PLL_ABSENT_MASK}; // RQ4 RQ6 RQ7 RQ8

    assign req        = av_req_i.read | av_req_i.write;
    assign hit_thread = (av_req_i.address == `CCR_OFF_THREAD); // RQ1 RQ5
    assign hit_pll    = (av_req_i.address == `CCR_OFF_PLL);    // RQ7

    // the answer is worked out from the request being taken and parked in
    // flops, so it stands unchanged until the next access is taken
    always_comb begin
        next_readdata = readdata_o;
        next_response = response_o;
        if (req && !ack) begin
            next_response = (hit_thread || hit_pll) ? `CCR_RESP_OKAY : `CCR_RESP_SLVERR;
            // writes are acknowledged but never stored
            if (av_req_i.read) begin
                unique case (1'b1)
                    hit_thread: next_readdata = thread_word; // RQ1
                    hit_pll:    next_readdata = pll_word;    // RQ4
                    default:    next_readdata = `CCR_RDATA_RST;
                endcase
            end
        end
    end

    // one wait cycle per access; ack drops after one cycle so a held
    // request is never answered twice
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ack <= 1'b0;
        end else begin
            ack <= req & ~ack;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            waitrequest_o <= 1'b1;
        end else begin
            waitrequest_o <= ~(req & ~ack);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            readdata_o <= `CCR_RDATA_RST;
            response_o <= `CCR_RESP_OKAY;
        end else begin
            readdata_o <= next_readdata;
            response_o <= next_response;
        end
    end

    a_thread_read_value: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RQ1
        (av_req_i.read && !waitrequest_o && av_req_i.address == `CCR_OFF_THREAD)
        |-> (readdata_o == thread_layout(THREAD_TWO_MASK)))
        else $error("thread capability read returned wrong word");

    a_core_field_layout: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RQ2
        (thread_word[31:30] == {1'b0, THREAD_TWO_MASK[15]}) && (thread_word[1:0] == {1'b0, THREAD_TWO_MASK[0]}))
        else $error("core thread field misplaced");

    a_no_reserved_code: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RQ3
        (av_req_i.read && !waitrequest_o && av_req_i.address == `CCR_OFF_THREAD)
        |-> ((readdata_o & `CCR_THREAD_HI_BITS) == 32'h0000_0000))
        else $error("reserved thread encoding reported");

    a_pll_read_value: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RQ4
        (av_req_i.read && !waitrequest_o && av_req_i.address == `CCR_OFF_PLL)
        |-> (readdata_o[15:0] == PLL_ABSENT_MASK && response_o == `CCR_RESP_OKAY))
        else $error("pll presence read returned wrong bits");

    a_thread_always_ok: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RQ5
        (av_req_i.read && !waitrequest_o && av_req_i.address == `CCR_OFF_THREAD)
        |-> (response_o == `CCR_RESP_OKAY))
        else $error("thread capability read refused");

    a_pll_upper_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RQ6
        (av_req_i.read && !waitrequest_o && av_req_i.address == `CCR_OFF_PLL)
        |-> (readdata_o[31:16] == 16'h0000))
        else $error("pll presence reserved bits not zero");

    a_answer_latency: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RQ5
        (req && waitrequest_o && !$past(req)) |=> !waitrequest_o ##1 waitrequest_o)
        else $error("access not answered in one wait cycle");

    a_write_no_effect: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RQ8
        av_req_i.write |=> ($stable(readdata_o) && $stable(pll_word) && $stable(thread_word)))
        else $error("write disturbed register contents");

    // build values hold for any mask; only the default masks give the reset words
    a_thread_default_word: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RQ1
        (THREAD_TWO_MASK != `CCR_THREAD_TWO_DEF) || (thread_word == `CCR_RST_THREAD))
        else $error("thread capability default word wrong");

    a_pll_default_word: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RQ7
        (PLL_ABSENT_MASK != `CCR_PLL_ABSENT_DEF) || (pll_word == `CCR_RST_PLL))
        else $error("pll presence default word wrong");

    // reset: waitrequest raised, read data and response cleared
    a_reset_outputs: assert property (@(posedge clk_sys_i) // RQ1
        rst_i |=> (waitrequest_o && readdata_o == `CCR_RDATA_RST && response_o == `CCR_RESP_OKAY))
        else $error("bus outputs not cleared by reset");

    a_unmapped_refused: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RQ1 RQ7
        (req && !waitrequest_o && av_req_i.address != `CCR_OFF_THREAD && av_req_i.address != `CCR_OFF_PLL)
        |-> (response_o == `CCR_RESP_SLVERR && (av_req_i.write || readdata_o == `CCR_RDATA_RST)))
        else $error("unmapped access not refused");

    a_write_accepted: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RQ8
        (av_req_i.write && !waitrequest_o
            && (av_req_i.address == `CCR_OFF_THREAD || av_req_i.address == `CCR_OFF_PLL))
        |-> (response_o == `CCR_RESP_OKAY))
        else $error("write to a capability register refused");

    a_idle_wait: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RQ5
        !req |=> waitrequest_o)
        else $error("waitrequest low with no access");

    a_single_answer: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RQ5
        !waitrequest_o |=> waitrequest_o)
        else $error("access answered twice");

    a_take_once: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RQ5
        ack |=> !ack)
        else $error("held request taken twice");

    a_idle_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RQ8
        !req |=> ($stable(readdata_o) && $stable(response_o)))
        else $error("bus answer changed while idle");

    // one check per core so a failure names the field that moved
    for (genvar gc = 0; gc < `CCR_NUM_CORES; gc++) begin : g_core_chk
        a_core_field: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RQ2 RQ3
            (thread_word[gc*`CCR_FIELD_W +: `CCR_FIELD_W] == {1'b0, THREAD_TWO_MASK[gc]}))
            else $error("core thread field does not match build mask");
    end

    // absent inputs read one, present inputs read zero
    for (genvar gp = 0; gp < `CCR_NUM_PLL; gp++) begin : g_pll_chk
        a_pll_input_bit: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RQ4
            (av_req_i.read && !waitrequest_o && av_req_i.address == `CCR_OFF_PLL)
            |-> (readdata_o[gp] == PLL_ABSENT_MASK[gp]))
            else $error("pll input flag wrong");
    end

    c_thread_read: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        av_req_i.read && !waitrequest_o && av_req_i.address == `CCR_OFF_THREAD);

    c_pll_read: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        av_req_i.read && !waitrequest_o && av_req_i.address == `CCR_OFF_PLL);

    c_unmapped: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        req && !waitrequest_o && response_o == `CCR_RESP_SLVERR);

    c_write: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        av_req_i.write && !waitrequest_o);

    c_back_to_back: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        !waitrequest_o ##3 !waitrequest_o);

endmodule // ccr_cap_regs

// ==== cluster_capability_regs_test.sv ====
/*
 * Self-checking bench for the cluster capability registers: two builds side by side, default and custom masks.
 * Assumes ccr_defs.svh on the include path and the one-wait-cycle Avalon-MM slave timing of the design.
 */
`timescale 1ns/1ns
`include "ccr_defs.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end

module cluster_capability_regs_test;
    // non-default masks expose shifted field mappings and swaps of cores whose mask bits differ
    localparam logic [15:0] T2 = 16'hA5C3;
    localparam logic [15:0] PA = 16'h3C5A;
    logic                 clk_sys_i  = 1'b0;
    logic                 rst_i      = 1'b1;
    ccr_pkg::ccr_av_req_t req        = '0;
    logic [31:0]          rd_a;
    logic [31:0]          rd_b;
    logic [1:0]           rs_a;
    logic [1:0]           rs_b;
    logic                 wt_a;
    logic                 wt_b;
    int                   fail_count = 0;
    int                   n_tests    = 0;
    int                   seed       = 31;

    always #2 clk_sys_i = ~clk_sys_i;

    ccr_cap_regs dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .av_req_i(req), .readdata_o(rd_a),
        .response_o(rs_a), .waitrequest_o(wt_a));
    ccr_cap_regs #(.THREAD_TWO_MASK(T2), .PLL_ABSENT_MASK(PA)) dut_b (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .av_req_i(req), .readdata_o(rd_b), .response_o(rs_b), .waitrequest_o(wt_b));

    function automatic logic [31:0] exp_word(input logic [11:0] a, input logic [15:0] tm, input logic [15:0] pm);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (a == `CCR_OFF_THREAD) begin
            for (int n = 0; n < 16; n++) begin
                w[2*n] = tm[n];
            end
        end
        if (a == `CCR_OFF_PLL) begin
            w = {16'h0000, pm};
        end
        return w;
    endfunction

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // one access; request held until waitrequest is sampled low, then checked on both builds
    task automatic op(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
        int   k;
        logic mapped;
        mapped = (a == `CCR_OFF_PLL) || (a == `CCR_OFF_THREAD);
        @(posedge clk_sys_i);
        req.read       <= !wr;
        req.write      <= wr;
        req.address    <= a;
        req.writedata  <= d;
        req.byteenable <= be;
        for (k = 0; k < 20; k++) begin
            @(posedge clk_sys_i);
            if (wt_a === 1'b0) begin
                break;
            end
        end
        if (k == 20) begin
            fail_count++;
            $display("MISMATCH t=%0t no answer", $time);
            test_done();
        end
        `CHK(wt_b, 1'b0)
        `CHK(rs_a, mapped ? `CCR_RESP_OKAY : `CCR_RESP_SLVERR)
        `CHK(rs_b, mapped ? `CCR_RESP_OKAY : `CCR_RESP_SLVERR)
        if (!wr) begin
            `CHK(rd_a, exp_word(a, `CCR_THREAD_TWO_DEF, `CCR_PLL_ABSENT_DEF))
            `CHK(rd_b, exp_word(a, T2, PA))
        end
        req.read  <= 1'b0;
        req.write <= 1'b0;
    endtask

    initial begin
        logic [31:0] r;
        repeat (12) @(posedge clk_sys_i);
        `CHK(wt_a, 1'b1)
        `CHK(rd_a, `CCR_RDATA_RST)
        rst_i <= 1'b0;
        op(1'b0, `CCR_OFF_THREAD, 32'h0, 4'hF);
        op(1'b0, `CCR_OFF_PLL, 32'h0, 4'hF);
        op(1'b1, `CCR_OFF_THREAD, 32'hFFFF_FFFF, 4'hF);
        op(1'b1, `CCR_OFF_PLL, 32'hFFFF_FFFF, 4'hF);
        op(1'b0, `CCR_OFF_THREAD, 32'h0, 4'hF);
        op(1'b0, `CCR_OFF_PLL, 32'h0, 4'hF);
        op(1'b0, 12'hFB8, 32'h0, 4'hF);
        for (int i = 0; i < 60; i++) begin
            r = $random(seed);
            op(r[14], (r[1:0] == 2'h0) ? `CCR_OFF_PLL : (r[1:0] == 2'h1) ? `CCR_OFF_THREAD : r[13:2],
                $random(seed), r[18:15]);
        end
        // reset again mid-run; values must come back unchanged
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        `CHK(wt_a, 1'b1)
        `CHK(rd_a, `CCR_RDATA_RST)
        `CHK(rs_a, `CCR_RESP_OKAY)
        `CHK(rd_b, `CCR_RDATA_RST)
        op(1'b0, `CCR_OFF_PLL, 32'h0, 4'hF);
        op(1'b0, `CCR_OFF_THREAD, 32'h0, 4'hF);
        test_done();
    end
endmodule // cluster_capability_regs_test
